// >>> nacp_pkg.sv
package nacp_pkg;
  // register map, byte addresses
  localparam int AW = 5;
  localparam logic [AW-1:0] OFS_CMD = 5'h00;
  localparam logic [AW-1:0] OFS_ACC = 5'h04;
  localparam logic [AW-1:0] OFS_YPTR = 5'h08;
  localparam logic [AW-1:0] OFS_XPTR = 5'h0c;
  localparam logic [AW-1:0] OFS_MEM = 5'h10;
  localparam logic [AW-1:0] OFS_STAT = 5'h14;
  localparam logic [AW-1:0] OFS_PINS = 5'h18;
  localparam logic [AW-1:0] OFS_WDOG = 5'h1c;
  // field positions
  localparam int CMD_IMM_LSB = 0;
  localparam int CMD_OP_LSB = 4;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_STOP_BIT = 1;
  localparam int STAT_PULSE_LSB = 2;
  localparam int PINS_R_LSB = 10;
  localparam int PINS_CAR_BIT = 14;
  // reset values
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [1:0] RST_X = 2'h0;
  localparam logic [9:0] RST_DLATCH = 10'h3ff;
  localparam logic [3:0] RST_RLATCH = 4'hf;
  // y pointer codes for output ops, and the pointer decrement addend
  localparam logic [3:0] Y_LAST_D = 4'h7;
  localparam logic [3:0] Y_CAR = 4'h8;
  localparam logic [3:0] Y_ALL_D = 4'h9;
  localparam logic [3:0] Y_R_LO = 4'ha;
  localparam logic [3:0] Y_R_HI = 4'hd;
  localparam logic [3:0] Y_ALL_R = 4'he;
  localparam logic [3:0] Y_ALL = 4'hf;
  localparam logic [3:0] NIB_DEC = 4'hf;
  // carrier divider and watchdog counter widths
  localparam int PULSE_BITS = 8;
  localparam int WDT_W = 16;

  typedef enum logic [4:0] {
    nop_op = 5'h00,
    pointer_decrement_op = 5'h01,
    xor_memory_op = 5'h02,
    negate_acc_op = 5'h03,
    acc_le_memory_op = 5'h04,
    acc_le_immediate_op = 5'h05,
    memory_nonzero_op = 5'h06,
    pointer_ne_acc_op = 5'h07,
    pointer_ne_immediate_op = 5'h08,
    key_nonzero_op = 5'h09,
    bidir_nonzero_op = 5'h0a,
    load_acc_from_keys_op = 5'h0b,
    load_acc_from_bidir_op = 5'h0c,
    output_set_op = 5'h0d,
    output_reset_op = 5'h0e,
    watchdog_clear_op = 5'h0f,
    stop_op = 5'h10,
    pulse_mode_load_op = 5'h11
  } nacp_op_e;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [3:0] acc;
    logic [3:0] y;
    logic [1:0] x;
    logic status_flag;
    logic stopped;
    logic [3:0] pulse_mode_register;
    logic [9:0] d_latch;
    logic [3:0] r_latch;
    logic [3:0] r_oe;
    logic car_en;
    logic carrier;
    logic [PULSE_BITS-1:0] div;
    logic [WDT_W-1:0] watchdog_counter;
    logic wdt_ovf;
    logic [63:0][3:0] mem;
  } nacp_state_s;
endpackage

// >>> nacp_core.sv
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Behaviour
// - pointer decrement, flag when old nonzero
// - acc xor memory, flag set
// - acc negated, flag when acc zero
// - flag when acc not above memory
// - flag when acc not above immediate
// - flag when memory nibble nonzero
// - flag when pointer differs from acc
// - flag when pointer differs from immediate
// - flag when key port nonzero
// - flag when bidirectional pins nonzero
// - acc loaded from keys, flag set
// - acc loaded from bidirectional pins, flag set
// - output set, single latch 0..7
// - output set at 8 enables carrier
// - output set at 9 sets ten latches
// - output set bidir latches, Eh, Fh
// - output reset latches, carrier, all ten
// - output reset bidir latches Ah..Eh
// - watchdog clear zeroes the counter
// - stop halts clocks, flag set
// - pulse mode loaded from pointer
module nacp_core import nacp_pkg::*; #(
  parameter logic [WDT_W-1:0] WDT_LIMIT = 16'hffff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // port pins
  input wire logic [3:0] key_in,
  input wire logic [3:0] bidir_in,
  output logic [3:0] bidir_out,
  output logic [3:0] bidir_oe,
  output logic [9:0] d_out,
  output logic carrier_out,
  // core state
  output logic status_flag,
  output logic stopped,
  output logic wdt_overflow
);

  // a zero limit would overflow every cycle
  if (WDT_LIMIT == '0) begin : g_bad
    $error("WDT_LIMIT must be nonzero");
  end

  // reset release synchroniser
  logic [1:0] rst_sync_q;
  logic rst_i_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_i_n = rst_sync_q[1];

  // nonzero test, shared by several ops
  function automatic logic f_nz(input logic [3:0] v);
    f_nz = (v != 4'h0);
  endfunction

  nacp_state_s s_q;
  nacp_state_s s_d;
  logic req;
  logic done;
  logic ex;
  nacp_op_e op;
  logic [3:0] imm;
  logic [3:0] mnib;
  logic wave;

  // bus handshake and decode
  assign req = avs_read | avs_write;
  assign done = req & ~s_q.wreq;
  assign ex = done & avs_write & (avs_address == OFS_CMD) & ~s_q.stopped;
  assign op = nacp_op_e'(avs_writedata[CMD_OP_LSB +: 5]);
  assign imm = avs_writedata[CMD_IMM_LSB +: 4];
  assign mnib = s_q.mem[{s_q.x, s_q.y}];
  // pulse mode above divider range gives a steady level
  assign wave = (s_q.pulse_mode_register >= 4'(PULSE_BITS)) ? 1'b1 :
                s_q.div[s_q.pulse_mode_register[2:0]];

  // next state
  always_comb begin
    s_d = s_q;
    s_d.wdt_ovf = 1'b0;
    // waitrequest idles high, drops one cycle per request
    if (req && s_q.wreq) begin
      s_d.wreq = 1'b0;
      case (avs_address)
        OFS_ACC: s_d.rdata = {28'h0, s_q.acc};
        OFS_YPTR: s_d.rdata = {28'h0, s_q.y};
        OFS_XPTR: s_d.rdata = {30'h0, s_q.x};
        OFS_MEM: s_d.rdata = {28'h0, mnib};
        OFS_STAT: s_d.rdata = {26'h0, s_q.pulse_mode_register, s_q.stopped, s_q.status_flag};
        OFS_PINS: s_d.rdata = {17'h0, s_q.car_en, s_q.r_latch, s_q.d_latch};
        OFS_WDOG: s_d.rdata = {16'h0, s_q.watchdog_counter};
        default: s_d.rdata = 32'h0;
      endcase
    end else if (done) begin
      s_d.wreq = 1'b1;
    end
    // free-running logic freezes while stopped
    if (!s_q.stopped) begin
      s_d.div = s_q.div + 1'b1;
      if (s_q.watchdog_counter == WDT_LIMIT) begin
        s_d.watchdog_counter = '0;
        s_d.wdt_ovf = 1'b1;
      end else begin
        s_d.watchdog_counter = s_q.watchdog_counter + 1'b1;
      end
    end else if (f_nz(key_in) || f_nz(bidir_in)) begin
      // any active key or port line wakes the core
      s_d.stopped = 1'b0;
    end
    // direct register writes
    if (done && avs_write && !s_q.stopped) begin
      case (avs_address)
        OFS_ACC: s_d.acc = avs_writedata[3:0];
        OFS_YPTR: s_d.y = avs_writedata[3:0];
        OFS_XPTR: s_d.x = avs_writedata[1:0];
        OFS_MEM: s_d.mem[{s_q.x, s_q.y}] = avs_writedata[3:0];
        default: ;
      endcase
    end
    if (ex) begin
      s_d.status_flag = 1'b1;
      case (op)
        pointer_decrement_op: begin
          s_d.y = s_q.y + NIB_DEC;
          s_d.status_flag = f_nz(s_q.y);
        end
        xor_memory_op: s_d.acc = s_q.acc ^ mnib;
        negate_acc_op: begin
          s_d.acc = ~s_q.acc + 4'h1;
          s_d.status_flag = ~f_nz(s_q.acc);
        end
        acc_le_memory_op: s_d.status_flag = (s_q.acc <= mnib);
        acc_le_immediate_op: s_d.status_flag = (s_q.acc <= imm);
        memory_nonzero_op: s_d.status_flag = f_nz(mnib);
        pointer_ne_acc_op: s_d.status_flag = (s_q.y != s_q.acc);
        pointer_ne_immediate_op: s_d.status_flag = (s_q.y != imm);
        key_nonzero_op: s_d.status_flag = f_nz(key_in);
        bidir_nonzero_op: s_d.status_flag = f_nz(bidir_in);
        load_acc_from_keys_op: s_d.acc = key_in;
        load_acc_from_bidir_op: s_d.acc = bidir_in;
        output_set_op: begin
          if (s_q.y <= Y_LAST_D) begin
            s_d.d_latch[s_q.y[2:0]] = 1'b1;
          end else if (s_q.y == Y_CAR) begin
            s_d.car_en = 1'b1;
          end else if (s_q.y == Y_ALL_D) begin
            s_d.d_latch = '1;
          end else if (s_q.y <= Y_R_HI) begin
            s_d.r_latch[s_q.y[1:0] - 2'h2] = 1'b1;
          end else if (s_q.y == Y_ALL_R) begin
            s_d.r_latch = '1;
          end else begin
            s_d.r_latch = '1;
            s_d.d_latch = '1;
          end
        end
        output_reset_op: begin
          if (s_q.y <= Y_LAST_D) begin
            s_d.d_latch[s_q.y[2:0]] = 1'b0;
          end else if (s_q.y == Y_CAR) begin
            s_d.car_en = 1'b0;
          end else if (s_q.y == Y_ALL_D) begin
            s_d.d_latch = '0;
          end else if (s_q.y <= Y_R_HI) begin
            s_d.r_latch[s_q.y[1:0] - 2'h2] = 1'b0;
          end else if (s_q.y == Y_ALL_R) begin
            s_d.r_latch = '0;
          end else begin
            // Fh behaves as on set: all released
            s_d.r_latch = '1;
            s_d.d_latch = '1;
          end
        end
        watchdog_clear_op: begin
          s_d.watchdog_counter = '0;
          s_d.wdt_ovf = 1'b0;
        end
        stop_op: s_d.stopped = 1'b1;
        pulse_mode_load_op: s_d.pulse_mode_register = s_q.y;
        default: ;
      endcase
    end
    // open drain: pull low only where latch is 0
    s_d.r_oe = ~s_d.r_latch;
    // carrier gated by pulse mode wave
    s_d.carrier = s_q.car_en & wave & ~s_q.stopped;
  end

  // all state registered here
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      s_q <= '0;
      s_q.wreq <= 1'b1;
      s_q.acc <= RST_NIB;
      s_q.y <= RST_NIB;
      s_q.x <= RST_X;
      s_q.status_flag <= 1'b1;
      s_q.pulse_mode_register <= RST_NIB;
      s_q.d_latch <= RST_DLATCH;
      s_q.r_latch <= RST_RLATCH;
      s_q.r_oe <= ~RST_RLATCH;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wreq;
  assign bidir_out = s_q.r_latch;
  assign bidir_oe = s_q.r_oe;
  assign d_out = s_q.d_latch;
  assign carrier_out = s_q.carrier;
  assign status_flag = s_q.status_flag;
  assign stopped = s_q.stopped;
  assign wdt_overflow = s_q.wdt_ovf;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_i_n);

  property p_ptr_dec;
    ex && op == pointer_decrement_op |=>
      s_q.y == $past(s_q.y) - 4'h1 && s_q.status_flag == ($past(s_q.y) != 4'h0);
  endproperty
  a_ptr_dec: assert property (p_ptr_dec) else $error("pointer decrement wrong");

  property p_neg;
    ex && op == negate_acc_op |=>
      s_q.acc == 4'h0 - $past(s_q.acc) && s_q.status_flag == ($past(s_q.acc) == 4'h0);
  endproperty
  a_neg: assert property (p_neg) else $error("negate wrong");

  property p_acc_le_mem;
    ex && op == acc_le_memory_op |=> s_q.status_flag == ($past(s_q.acc) <= $past(mnib))
      && $stable(s_q.acc);
  endproperty
  a_acc_le_mem: assert property (p_acc_le_mem) else $error("memory compare wrong");

  property p_yne;
    ex && op == pointer_ne_immediate_op |=> s_q.status_flag == ($past(s_q.y) != $past(imm));
  endproperty
  a_yne: assert property (p_yne) else $error("immediate inequality wrong");

  property p_key_nz;
    ex && op == key_nonzero_op |=> s_q.status_flag == ($past(key_in) != 4'h0);
  endproperty
  a_key_nz: assert property (p_key_nz) else $error("key test wrong");

  property p_so;
    ex && op == output_set_op && s_q.y <= 4'h7 |=> d_out[$past(s_q.y[2:0])] ##1 d_out[$past(s_q.y[2:0], 2)];
  endproperty
  a_so: assert property (p_so) else $error("output set lost");

  property p_clr_all_d;
    ex && op == output_reset_op && s_q.y == 4'h9 |=> d_out == 10'h000;
  endproperty
  a_clr_all_d: assert property (p_clr_all_d) else $error("reset all d failed");

  property p_wdog_clr;
    ex && op == watchdog_clear_op |=> s_q.watchdog_counter == '0 && !wdt_overflow;
  endproperty
  a_wdog_clr: assert property (p_wdog_clr) else $error("watchdog not cleared");

  property p_stop;
    ex && op == stop_op |=> stopped && status_flag ##1 (stopped || $past(key_in) != 4'h0 || $past(bidir_in) != 4'h0);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");

  property p_nop;
    ex && op == nop_op |=> status_flag && $stable(s_q.acc) && $stable(s_q.y);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");

  property p_wait;
    req && s_q.wreq |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong"); // bus handshake

  property p_xor_mem;
    ex && op == xor_memory_op |=> s_q.acc == ($past(s_q.acc) ^ $past(mnib)) && s_q.status_flag;
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor with memory wrong");

  property p_acc_le_imm;
    ex && op == acc_le_immediate_op |=> s_q.status_flag == ($past(s_q.acc) <= $past(imm)) && $stable(s_q.acc);
  endproperty
  a_acc_le_imm: assert property (p_acc_le_imm) else $error("immediate compare wrong");

  property p_mem_nz;
    ex && op == memory_nonzero_op |=> s_q.status_flag == ($past(mnib) != 4'h0);
  endproperty
  a_mem_nz: assert property (p_mem_nz) else $error("memory zero test wrong");

  property p_ptr_ne_acc;
    ex && op == pointer_ne_acc_op |=> s_q.status_flag == ($past(s_q.y) != $past(s_q.acc));
  endproperty
  a_ptr_ne_acc: assert property (p_ptr_ne_acc) else $error("pointer versus acc wrong");

  property p_bidir_nz;
    ex && op == bidir_nonzero_op |=> s_q.status_flag == ($past(bidir_in) != 4'h0);
  endproperty
  a_bidir_nz: assert property (p_bidir_nz) else $error("bidir test wrong");

  property p_load_keys;
    ex && op == load_acc_from_keys_op |=> s_q.acc == $past(key_in) && s_q.status_flag;
  endproperty
  a_load_keys: assert property (p_load_keys) else $error("load from keys wrong");

  property p_load_bidir;
    ex && op == load_acc_from_bidir_op |=> s_q.acc == $past(bidir_in) && s_q.status_flag;
  endproperty
  a_load_bidir: assert property (p_load_bidir) else $error("load from bidir wrong");

  property p_car_on;
    ex && op == output_set_op && s_q.y == 4'h8 |=> s_q.car_en;
  endproperty
  a_car_on: assert property (p_car_on) else $error("carrier not enabled");

  property p_set_all_d;
    ex && op == output_set_op && s_q.y == 4'h9 |=> d_out == 10'h3ff;
  endproperty
  a_set_all_d: assert property (p_set_all_d) else $error("set all d failed");

  property p_set_all;
    ex && op == output_set_op && s_q.y == 4'hf |=> d_out == 10'h3ff && bidir_out == 4'hf;
  endproperty
  a_set_all: assert property (p_set_all) else $error("set everything failed");

  property p_clr_all_r;
    ex && op == output_reset_op && s_q.y == 4'he |=> bidir_out == 4'h0 && bidir_oe == 4'hf;
  endproperty
  a_clr_all_r: assert property (p_clr_all_r) else $error("reset all bidir failed");

  property p_pulse_load;
    ex && op == pulse_mode_load_op |=> s_q.pulse_mode_register == $past(s_q.y);
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("pulse mode not loaded");

  property p_flag_hold;
    !ex |=> $stable(s_q.status_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved without command");
endmodule

// >>> nacp_pins.sv
`timescale 1ns/1ps
// far side: key switches and open-drain lines on the bidir port
module nacp_pins import nacp_pkg::*; (
  // bench side
  input wire logic [3:0] key_set,
  input wire logic [3:0] r_ext,
  // device side
  input wire logic [3:0] bidir_out,
  input wire logic [3:0] bidir_oe,
  output logic [3:0] key_in,
  output logic [3:0] bidir_in
);
  // keys are plain levels
  assign key_in = key_set;
  // a driven low latch wins, else the outside level given on r_ext
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bidir_in[i] = (bidir_oe[i] & ~bidir_out[i]) ? 1'b0 : r_ext[i];
    end
  end
endmodule

// >>> nacp_core_tb.sv
`timescale 1ns/1ps
module nacp_core_tb import nacp_pkg::*; ;
  // one row: op, nibbles {imm,acc,y,mem,key,r,exp acc,exp y}, exp flag
  typedef struct packed {
    nacp_op_e op;
    logic [31:0] v;
    logic ef;
  } nacp_row_s;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [AW-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] key_set, r_ext, key_in, bidir_in, bidir_out, bidir_oe, r_e;
  logic [9:0] d_out, d_e;
  logic carrier_out, status_flag, stopped, wdt_overflow, c_e;
  int miscompares, checked, n;
  nacp_row_s row;
  // rows ordered so that every set-only op follows a cleared flag
  nacp_row_s tbl [22] = '{
    '{pointer_decrement_op, 32'h0000000f, 1'h0},
    '{nop_op, 32'h0, 1'h1},
    '{pointer_decrement_op, 32'h00100000, 1'h1},
    '{negate_acc_op, 32'h030000d0, 1'h0},
    '{xor_memory_op, 32'h050c0090, 1'h1},
    '{negate_acc_op, 32'h0, 1'h1},
    '{acc_le_memory_op, 32'h06050060, 1'h0},
    '{acc_le_memory_op, 32'h05050050, 1'h1},
    '{acc_le_immediate_op, 32'h23000030, 1'h0},
    '{acc_le_immediate_op, 32'hff0000f0, 1'h1},
    '{memory_nonzero_op, 32'h0, 1'h0},
    '{memory_nonzero_op, 32'h00380003, 1'h1},
    '{pointer_ne_acc_op, 32'h0aa000aa, 1'h0},
    '{pointer_ne_acc_op, 32'h02100021, 1'h1},
    '{pointer_ne_immediate_op, 32'hf0f0000f, 1'h0},
    '{pointer_ne_immediate_op, 32'hf0000000, 1'h1},
    '{key_nonzero_op, 32'h00004000, 1'h1},
    '{key_nonzero_op, 32'h0, 1'h0},
    '{load_acc_from_keys_op, 32'h00009090, 1'h1},
    '{bidir_nonzero_op, 32'h00000200, 1'h1},
    '{bidir_nonzero_op, 32'h0, 1'h0},
    '{load_acc_from_bidir_op, 32'h00000660, 1'h1}
  };
  // short watchdog so a wrap is seen quickly
  nacp_core #(.WDT_LIMIT(16'h0010)) nacp_core_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .key_in(key_in), .bidir_in(bidir_in), .bidir_out(bidir_out),
    .bidir_oe(bidir_oe), .d_out(d_out), .carrier_out(carrier_out), .status_flag(status_flag),
    .stopped(stopped), .wdt_overflow(wdt_overflow));
  nacp_pins nacp_pins_inst (.key_set(key_set), .r_ext(r_ext), .bidir_out(bidir_out), .bidir_oe(bidir_oe),
    .key_in(key_in), .bidir_in(bidir_in));
  // 25 ns clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // single exit point
  task give_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hold the request until waitrequest is sampled low, bounded
  task wait_ack;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      give_verdict;
    end
  endtask
  // extra edge after release so the next request never lands in the same step
  task bus_wr(input logic [AW-1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task bus_rd(input logic [AW-1:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack;
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task cmd(input nacp_op_e op, input logic [3:0] i);
    bus_wr(OFS_CMD, {23'h0, op, i});
  endtask
  // output latch op plus expected latch image
  task out_op(input logic set, input logic [3:0] y);
    bus_wr(OFS_YPTR, {28'h0, y});
    cmd(set ? output_set_op : output_reset_op, 4'h0);
    if (y <= Y_LAST_D) begin
      d_e[y] = set;
    end else if (y == Y_CAR) begin
      c_e = set;
    end else if (y == Y_ALL_D) begin
      d_e = {10{set}};
    end else if (y <= Y_R_HI) begin
      r_e[y - Y_R_LO] = set;
    end else if (y == Y_ALL_R) begin
      r_e = {4{set}};
    end else begin
      // both set and reset release everything here
      d_e = 10'h3ff;
      r_e = 4'hf;
    end
    bus_rd(OFS_PINS);
    chk(rd, {17'h0, c_e, r_e, d_e});
    chk({13'h0, carrier_out, bidir_oe, bidir_out, d_out}, {13'h0, c_e, ~r_e, r_e, d_e});
  endtask
  initial begin
    miscompares = 0;
    checked = 0;
    rst_n <= 1'b0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= 5'h00;
    avs_writedata <= 32'h0;
    key_set <= 4'h0;
    r_ext <= 4'h0;
    repeat (20) @(posedge clk);
    // idle levels while held in reset
    chk({9'h0, d_out, bidir_out, bidir_oe, status_flag, stopped, avs_waitrequest, carrier_out, wdt_overflow},
      {9'h0, 10'h3ff, 4'hf, 4'h0, 3'h5, 2'h0});
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus_rd(OFS_PINS);
    chk(rd, 32'h00003fff);
    bus_rd(5'h12);
    chk(rd, 32'h0);
    // table of flag and accumulator ops
    for (int k = 0; k < 22; k++) begin
      row = tbl[k];
      key_set <= row.v[15:12];
      r_ext <= row.v[11:8];
      bus_wr(OFS_YPTR, {28'h0, row.v[23:20]});
      bus_wr(OFS_MEM, {28'h0, row.v[19:16]});
      bus_wr(OFS_ACC, {28'h0, row.v[27:24]});
      cmd(row.op, row.v[31:28]);
      chk({31'h0, status_flag}, {31'h0, row.ef});
      bus_rd(OFS_ACC);
      chk(rd & 32'hf, {28'h0, row.v[7:4]});
      bus_rd(OFS_YPTR);
      chk(rd & 32'hf, {28'h0, row.v[3:0]});
    end
    // memory nibble must follow the x pointer as well as y
    bus_wr(OFS_XPTR, 32'h1);
    bus_wr(OFS_YPTR, 32'h0);
    bus_wr(OFS_MEM, 32'ha);
    bus_wr(OFS_XPTR, 32'h0);
    bus_wr(OFS_MEM, 32'h3);
    bus_wr(OFS_XPTR, 32'h1);
    bus_wr(OFS_ACC, 32'h6);
    cmd(xor_memory_op, 4'h0);
    bus_rd(OFS_ACC);
    chk(rd, 32'hc);
    // steady carrier selected so the pin follows the latch
    bus_wr(OFS_YPTR, 32'h8);
    cmd(pulse_mode_load_op, 4'h0);
    bus_rd(OFS_STAT);
    chk(rd & 32'h3c, 32'h20);
    d_e = 10'h3ff;
    r_e = 4'hf;
    c_e = 1'b0;
    out_op(1'b0, Y_ALL_D);
    out_op(1'b0, Y_ALL_R);
    // set sweep from all low, then reset sweep from all released
    for (int s = 1; s >= 0; s--) begin
      for (int y = 0; y < 16; y++) begin
        out_op(s[0], y[3:0]);
      end
    end
    // group codes Eh and Fh from a state where they differ
    out_op(1'b0, Y_ALL_D);
    out_op(1'b0, Y_ALL_R);
    out_op(1'b1, Y_ALL_R);
    out_op(1'b0, Y_ALL_R);
    out_op(1'b1, Y_ALL);
    // fastest divider tap must toggle the carrier pin every cycle
    bus_wr(OFS_YPTR, 32'h8);
    cmd(output_set_op, 4'h0);
    bus_wr(OFS_YPTR, 32'h0);
    cmd(pulse_mode_load_op, 4'h0);
    @(posedge clk);
    c_e = carrier_out;
    @(posedge clk);
    chk({31'h0, carrier_out ^ c_e}, 32'h1);
    cmd(watchdog_clear_op, 4'h0);
    bus_rd(OFS_WDOG);
    chk({31'h0, rd < 32'h8}, 32'h1);
    // counter left alone must wrap within limit plus margin
    n = 0;
    while (wdt_overflow !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, wdt_overflow}, 32'h1);
    key_set <= 4'h0;
    r_ext <= 4'h0;
    cmd(stop_op, 4'h0);
    chk({30'h0, stopped, status_flag}, 32'h3);
    // a key press wakes the core
    key_set <= 4'h1;
    n = 0;
    while (stopped !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, stopped}, 32'h0);
    // reset in mid-run returns everything to idle
    bus_wr(OFS_ACC, 32'h5);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({9'h0, d_out, bidir_out, bidir_oe, status_flag, stopped, avs_waitrequest, carrier_out, wdt_overflow},
      {9'h0, 10'h3ff, 4'hf, 4'h0, 3'h5, 2'h0});
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus_rd(OFS_ACC);
    chk(rd, 32'h0);
    give_verdict;
  end
endmodule
